/* File: bench/ptmc_host.sv */
// Purpose: host side model that programs the configuration bank
// Assumes: writes are taken on the rising edge, reads are combinational
// Notes: signals change only at falling edges; wdata is scrambled once released
`timescale 1ns/1ps
module ptmc_host (
	// clock
	input wire logic sys_clk,
	// register access
	output logic [5:0] reg_index,
	output logic reg_write,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_index = 6'h00;
		reg_write = 1'b0;
		reg_wdata = 8'h00;
	end
	task automatic wr(input logic [5:0] idx, input logic [7:0] val);
		@(negedge sys_clk);
		reg_index = idx;
		reg_wdata = val;
		reg_write = 1'b1;
		@(negedge sys_clk);
		reg_write = 1'b0;
		// released data must not look like the last value
		reg_wdata = ~val;
	endtask
	task automatic rd(input logic [5:0] idx, output logic [7:0] val);
		@(negedge sys_clk);
		reg_index = idx;
		@(posedge sys_clk);
		val = reg_rdata;
	endtask
	// join bits are written alone before the enables follow
	task automatic setup(input logic [7:0] master);
		wr(ptmc_pkg::MASTER_CFG_ADDR, master & 8'h0B);
		wr(ptmc_pkg::MASTER_CFG_ADDR, master);
	endtask
endmodule

/* File: bench/test_ptmc_config.sv */
// Purpose: self-checking bench for the configuration bank
// Assumes: datapath inputs driven at falling edges, 100 ns clock
// Notes: only fixed waits; a watchdog ends a hung run
`timescale 1ns/1ps
module test_ptmc_config;
	logic sys_clk, reset_n, reg_write, first_pend_clear, second_pend_clear;
	logic ack_in_pin_level, timer_one_out;
	logic [5:0] reg_index;
	logic [7:0] reg_wdata, reg_rdata, first_drive_req, second_drive_req, rv;
	ptmc_pkg::ptmc_port_stat_type first_stat, second_stat;
	logic first_pending, first_request, first_catch_transparent, first_skew_start;
	logic second_pending, second_request, second_catch_transparent, second_skew_start;
	logic first_one_deep, first_latch_on_match, second_one_deep, second_latch_on_match;
	logic [1:0] first_match_mode, second_match_mode, timer_join_select;
	logic [7:0] first_oe_n, second_oe_n;
	logic ports_joined, handshake_idle, internal_acknowledge_input;
	logic timer_one_enable, timer_two_enable, third_port_timer_enable;
	logic timer_two_gate, timer_two_trigger, timer_two_count_in, timer_two_ext_count_clear;
	logic [2:0] timer_hold_init;
	int failures, cmp_count;
	ptmc_config u_dut (.*);
	ptmc_host u_host (.sys_clk(sys_clk), .reg_index(reg_index), .reg_write(reg_write),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rchk(input logic [5:0] idx, input logic [7:0] exp);
		u_host.rd(idx, rv);
		chk(rv, exp);
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// one-cycle pulse of a datapath event from falling edge to falling edge, registered at the rising edge inside it, then one more falling edge
	task automatic pulse(input logic sel, input logic [4:0] ev);
		@(negedge sys_clk);
		if (sel) second_stat = ev; else first_stat = ev;
		@(negedge sys_clk);
		second_stat = 5'h00;
		first_stat = 5'h00;
		@(negedge sys_clk);
	endtask
	initial begin
		#5000000;
		failures++;
		final_report();
	end
	initial begin
		reset_n = 1'b0;
		{reg_write, first_pend_clear, second_pend_clear, timer_one_out} = 4'h0;
		ack_in_pin_level = 1'b0;
		first_stat = 5'h00;
		second_stat = 5'h00;
		first_drive_req = 8'h3C;
		second_drive_req = 8'h5A;
		repeat (6) @(negedge sys_clk);
		reset_n = 1'b1;
		rchk(ptmc_pkg::MASTER_CFG_ADDR, 8'h00);
		rchk(ptmc_pkg::FIRST_MODE_ADDR, 8'h00);
		rchk(ptmc_pkg::SECOND_MODE_ADDR, 8'h00);
		rchk(6'h02, 8'h00);
		chk({ports_joined, handshake_idle, internal_acknowledge_input}, 8'h03);
		chk({timer_hold_init, first_oe_n == 8'hFF, second_oe_n == 8'hFF}, 8'h1F);
		// bit port only, so byte-pair and match-only stay zero
		for (int m = 0; m < 4; m++) begin
			u_host.wr(ptmc_pkg::FIRST_MODE_ADDR, 8'(m << 1));
			rchk(ptmc_pkg::FIRST_MODE_ADDR, 8'(m << 1));
			chk(first_match_mode, 8'(m));
		end
		u_host.wr(ptmc_pkg::FIRST_MODE_ADDR, 8'h01);
		chk(first_latch_on_match, 8'h01);
		u_host.wr(ptmc_pkg::FIRST_MODE_ADDR, 8'h50);
		chk(first_one_deep, 8'h01);
		pulse(1'b1, 5'h01);
		chk(second_pending, 8'h00);
		chk(second_oe_n, 8'hFF);
		chk(second_catch_transparent, 8'h01);
		u_host.setup(8'h80);
		pulse(1'b1, 5'h01);
		chk(second_pending, 8'h01);
		chk(second_oe_n, 8'hA5);
		chk(second_catch_transparent, 8'h00);
		u_host.wr(ptmc_pkg::MASTER_CFG_ADDR, 8'h00);
		chk(second_pending, 8'h01);
		chk(second_oe_n, 8'hFF);
		pulse(1'b0, 5'h01);
		chk(first_pending, 8'h00);
		u_host.setup(8'h04);
		pulse(1'b0, 5'h01);
		chk(first_pending, 8'h01);
		chk(first_oe_n, 8'hC3);
		chk(first_catch_transparent, 8'h00);
		@(negedge sys_clk);
		first_pend_clear = 1'b1;
		@(negedge sys_clk);
		first_pend_clear = 1'b0;
		chk(first_pending, 8'h00);
		for (int j = 0; j < 4; j++) begin
			u_host.setup(8'h70 | 8'(j));
			chk(timer_join_select, 8'(j));
			chk({timer_two_gate, timer_two_trigger, timer_two_count_in} & 3'(1 << (3 - j)),
				8'(j == 0 ? 0 : 1 << (3 - j)));
			chk(timer_two_ext_count_clear, 8'(j == 3));
			chk(timer_hold_init, 8'h00);
			chk({third_port_timer_enable, handshake_idle, internal_acknowledge_input},
				8'h04);
		end
		ack_in_pin_level = 1'b1;
		#1 chk(internal_acknowledge_input, 8'h01);
		ack_in_pin_level = 1'b0;
		u_host.wr(ptmc_pkg::MASTER_CFG_ADDR, 8'h40);
		chk(timer_hold_init, 8'h06);
		chk({handshake_idle, internal_acknowledge_input}, 8'h03);
		u_host.wr(ptmc_pkg::FIRST_MODE_ADDR, 8'h40);
		u_host.setup(8'h14);
		@(negedge sys_clk);
		first_stat = 5'h10;
		#1 chk(first_request, 8'h01);
		u_host.wr(ptmc_pkg::FIRST_MODE_ADDR, 8'h60);
		chk(first_request, 8'h00);
		first_stat = 5'h18;
		#1 chk(first_request, 8'h01);
		u_host.wr(ptmc_pkg::FIRST_MODE_ADDR, 8'h00);
		chk(first_request, 8'h00);
		first_stat = 5'h00;
		// output handshake, no vector mode, skew bit set
		u_host.wr(ptmc_pkg::FIRST_MODE_ADDR, 8'h81);
		first_stat = 5'h04;
		#1 chk(first_skew_start, 8'h01);
		u_host.wr(ptmc_pkg::FIRST_MODE_ADDR, 8'h80);
		chk(first_skew_start, 8'h00);
		first_stat = 5'h00;
		u_host.wr(ptmc_pkg::SECOND_MODE_ADDR, 8'h00);
		u_host.setup(8'h0C);
		chk(ports_joined, 8'h01);
		rchk(ptmc_pkg::MASTER_CFG_ADDR, 8'h0C);
		final_report();
	end
endmodule

/* File: rtl/ptmc_config.sv */
// Purpose: master configuration and port mode registers with enable gating
// Assumes: register index and strobes from the pointer logic, same clock
// Notes: handshake and timer datapaths live in neighbouring blocks
// How it works
// - second port disabled: its pending flag cannot set, existing flag kept
// - second port disabled: no request/wait, catchers transparent, lines floated
// - timer disabled: no new flag, running flag cleared, read hold zero, triggers ignored
// - one enable bit gates third port and timer three alike
// - that enable low: both handshakes idle, acknowledge input forced high
// - port join set: one 16-bit port using first port's controls
// - first port enable gates first port like second port enable
// - timer join: independent, gate, trigger, or count input
// - port kind: bit, input, output, bidirectional
// - byte-pair set: flag needs both registers full or empty
// - request rises at one or two bytes, holds while bytes remain
// - one-deep set: byte loads both buffer and data registers
// - match-only: interrupt only for matching moved bytes
// - match mode: off, AND, OR, OR with priority vector
// - bit 0 on bit ports latches input data on match
// - bit 0 on output handshake ports starts skew delay timer
// - reset clears master configuration: all disabled and unjoined
`timescale 1ns/1ps
module ptmc_config (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// register access
	input wire logic [5:0] reg_index,
	input wire logic reg_write,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// first port datapath
	input wire ptmc_pkg::ptmc_port_stat_type first_stat,
	input wire logic first_pend_clear,
	input wire logic [7:0] first_drive_req,
	output logic first_pending,
	output logic first_request,
	output logic first_catch_transparent,
	output logic [7:0] first_oe_n,
	output logic first_skew_start,
	output logic first_one_deep,
	output logic first_latch_on_match,
	output logic [1:0] first_match_mode,
	// second port datapath
	input wire ptmc_pkg::ptmc_port_stat_type second_stat,
	input wire logic second_pend_clear,
	input wire logic [7:0] second_drive_req,
	output logic second_pending,
	output logic second_request,
	output logic second_catch_transparent,
	output logic [7:0] second_oe_n,
	output logic second_skew_start,
	output logic second_one_deep,
	output logic second_latch_on_match,
	output logic [1:0] second_match_mode,
	// joined port and handshake gating
	output logic ports_joined,
	output logic handshake_idle,
	output logic internal_acknowledge_input,
	input wire logic ack_in_pin_level,
	// timers
	input wire logic timer_one_out,
	output logic timer_one_enable,
	output logic timer_two_enable,
	output logic third_port_timer_enable,
	output logic [2:0] timer_hold_init,
	output logic [1:0] timer_join_select,
	output logic timer_two_gate,
	output logic timer_two_trigger,
	output logic timer_two_count_in,
	output logic timer_two_ext_count_clear
);
	logic [7:0] master_r;
	logic [7:0] master_nxt;
	logic [7:0] first_mode_r;
	logic [7:0] first_mode_nxt;
	logic [7:0] second_mode_r;
	logic [7:0] second_mode_nxt;
	ptmc_pkg::ptmc_port_ctl_type first_ctl;
	ptmc_pkg::ptmc_port_ctl_type second_ctl;
	ptmc_pkg::ptmc_tjoin_type tjoin;

	always_comb begin
		master_nxt = master_r;
		first_mode_nxt = first_mode_r;
		second_mode_nxt = second_mode_r;
		if (reg_write) begin
			case (reg_index)
				ptmc_pkg::MASTER_CFG_ADDR: master_nxt = reg_wdata;
				ptmc_pkg::FIRST_MODE_ADDR: first_mode_nxt = reg_wdata;
				ptmc_pkg::SECOND_MODE_ADDR: second_mode_nxt = reg_wdata;
				default: master_nxt = master_r;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			master_r <= ptmc_pkg::MASTER_CFG_RESET;
			first_mode_r <= ptmc_pkg::MODE_RESET;
			second_mode_r <= ptmc_pkg::MODE_RESET;
		end else begin
			master_r <= master_nxt;
			first_mode_r <= first_mode_nxt;
			second_mode_r <= second_mode_nxt;
		end
	end

	always_comb begin
		case (reg_index)
			ptmc_pkg::MASTER_CFG_ADDR: reg_rdata = master_r;
			ptmc_pkg::FIRST_MODE_ADDR: reg_rdata = first_mode_r;
			ptmc_pkg::SECOND_MODE_ADDR: reg_rdata = second_mode_r;
			default: reg_rdata = 8'h00;
		endcase
	end

	assign timer_one_enable = master_r[ptmc_pkg::TIMER_ONE_EN_BIT];
	assign timer_two_enable = master_r[ptmc_pkg::TIMER_TWO_EN_BIT];
	assign third_port_timer_enable = master_r[ptmc_pkg::THIRD_EN_BIT];
	assign ports_joined = master_r[ptmc_pkg::PORT_JOIN_BIT];
	assign timer_join_select = master_r[ptmc_pkg::TIMER_JOIN_LSB +: 2];
	assign tjoin = ptmc_pkg::ptmc_tjoin_type'(timer_join_select);

	// timers held initialized while disabled; third timer shares the port enable
	assign timer_hold_init = {!third_port_timer_enable, !timer_two_enable,
		!timer_one_enable};

	// handshake start-up is held back until the third enable is set
	assign handshake_idle = !third_port_timer_enable;
	assign internal_acknowledge_input = handshake_idle ? 1'b1 : ack_in_pin_level;

	// timer join routes timer one's inverted output to timer two's gate, trigger or count input
	always_comb begin
		timer_two_gate = 1'b1;
		timer_two_trigger = 1'b0;
		timer_two_count_in = 1'b0;
		timer_two_ext_count_clear = 1'b0;
		case (tjoin)
			ptmc_pkg::PTMC_TJ_INDEP: timer_two_gate = 1'b1;
			ptmc_pkg::PTMC_TJ_GATE: timer_two_gate = !timer_one_out;
			ptmc_pkg::PTMC_TJ_TRIG: timer_two_trigger = !timer_one_out;
			ptmc_pkg::PTMC_TJ_COUNT: begin
				timer_two_count_in = !timer_one_out;
				timer_two_ext_count_clear = 1'b1;
			end
			default: timer_two_gate = 1'b1;
		endcase
	end

	function automatic ptmc_pkg::ptmc_port_ctl_type decode(input logic [7:0] mode,
			input logic en, input logic idle);
		ptmc_pkg::ptmc_port_ctl_type c;
		ptmc_pkg::ptmc_kind_type kind;
		kind = ptmc_pkg::ptmc_kind_type'(mode[ptmc_pkg::KIND_LSB +: 2]);
		c.enabled = en;
		c.handshake_idle = idle;
		c.is_bit_port = (kind == ptmc_pkg::PTMC_KIND_BIT);
		c.is_input = (kind == ptmc_pkg::PTMC_KIND_IN);
		c.is_output = (kind == ptmc_pkg::PTMC_KIND_OUT);
		c.is_bidir = (kind == ptmc_pkg::PTMC_KIND_BIDIR);
		c.byte_pair = mode[ptmc_pkg::BYTE_PAIR_BIT];
		c.one_deep = mode[ptmc_pkg::ONE_DEEP_BIT] && !c.is_bit_port;
		c.match_only = mode[ptmc_pkg::MATCH_ONLY_BIT];
		c.match_mode = ptmc_pkg::ptmc_match_type'(mode[ptmc_pkg::MATCH_MODE_LSB +: 2]);
		// bit 0 means different things by port kind
		c.latch_on_match = mode[ptmc_pkg::LATCH_SKEW_BIT] && c.is_bit_port;
		c.skew_delay_enable = mode[ptmc_pkg::LATCH_SKEW_BIT] && c.is_output;
		return c;
	endfunction

	// second port's handshake fields are ignored while joined
	assign first_ctl = decode(first_mode_r, master_r[ptmc_pkg::FIRST_PORT_EN_BIT],
		handshake_idle);
	assign second_ctl = decode(ports_joined ? 8'h00 : second_mode_r,
		master_r[ptmc_pkg::SECOND_PORT_EN_BIT], handshake_idle);

	assign first_one_deep = first_ctl.one_deep;
	assign first_latch_on_match = first_ctl.latch_on_match;
	assign first_match_mode = first_ctl.match_mode;
	assign second_one_deep = second_ctl.one_deep;
	assign second_latch_on_match = second_ctl.latch_on_match;
	assign second_match_mode = second_ctl.match_mode;

	ptmc_port_gate u_first (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.ctl(first_ctl),
		.stat(first_stat),
		.pend_clear(first_pend_clear),
		.out_drive_req(first_drive_req),
		.interrupt_pending_flag(first_pending),
		.request_out(first_request),
		.catchers_transparent(first_catch_transparent),
		.io_oe_n(first_oe_n),
		.skew_start(first_skew_start)
	);

	ptmc_port_gate u_second (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.ctl(second_ctl),
		.stat(second_stat),
		.pend_clear(second_pend_clear),
		.out_drive_req(second_drive_req),
		.interrupt_pending_flag(second_pending),
		.request_out(second_request),
		.catchers_transparent(second_catch_transparent),
		.io_oe_n(second_oe_n),
		.skew_start(second_skew_start)
	);

	property p_reset_clears_master;
		@(posedge sys_clk) $rose(reset_n) |-> (master_r == 8'h00);
	endproperty
	a_reset_clears_master: assert property (p_reset_clears_master) else $error("master not clear");

	property p_write_lands;
		@(posedge sys_clk) disable iff (!reset_n)
		reg_write && reg_index == 6'h01 |=> master_r == $past(reg_wdata);
	endproperty
	a_write_lands: assert property (p_write_lands) else $error("master write lost");

	property p_second_floats;
		@(posedge sys_clk) disable iff (!reset_n)
		!master_r[7] |-> second_oe_n == 8'hFF && !second_request && second_catch_transparent;
	endproperty
	a_second_floats: assert property (p_second_floats) else $error("second port active");

	property p_first_floats;
		@(posedge sys_clk) disable iff (!reset_n)
		!master_r[2] |-> first_oe_n == 8'hFF && !first_request;
	endproperty
	a_first_floats: assert property (p_first_floats) else $error("first port active");

	property p_second_no_set;
		@(posedge sys_clk) disable iff (!reset_n)
		!master_r[7] && !second_pending |=> !second_pending;
	endproperty
	a_second_no_set: assert property (p_second_no_set) else $error("flag set while off");

	property p_ack_high;
		@(posedge sys_clk) disable iff (!reset_n)
		!master_r[4] |-> internal_acknowledge_input && !first_request && timer_hold_init[2];
	endproperty
	a_ack_high: assert property (p_ack_high) else $error("handshake not idle");

	property p_timer_hold;
		@(posedge sys_clk) disable iff (!reset_n)
		timer_hold_init[0] == !master_r[6] && timer_hold_init[1] == !master_r[5];
	endproperty
	a_timer_hold: assert property (p_timer_hold) else $error("timer hold wrong");

	property p_count_join;
		@(posedge sys_clk) disable iff (!reset_n)
		master_r[1:0] == 2'b11 |-> timer_two_count_in == !timer_one_out && timer_two_ext_count_clear;
	endproperty
	a_count_join: assert property (p_count_join) else $error("count join wrong");
endmodule

/* File: rtl/ptmc_pkg.sv */
// Purpose: shared constants and types for the port/timer master configuration bank
// Assumes: 6-bit register index, 8-bit data, one clock domain
// Notes: mode register fields are common to both handshake ports
package ptmc_pkg;
	localparam logic [5:0] MASTER_CFG_ADDR = 6'h01;
	localparam logic [5:0] FIRST_MODE_ADDR = 6'h20;
	localparam logic [5:0] SECOND_MODE_ADDR = 6'h28;
	localparam logic [7:0] MASTER_CFG_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET = 8'h00;
	// master configuration bit positions
	localparam int SECOND_PORT_EN_BIT = 7;
	localparam int TIMER_ONE_EN_BIT = 6;
	localparam int TIMER_TWO_EN_BIT = 5;
	localparam int THIRD_EN_BIT = 4;
	localparam int PORT_JOIN_BIT = 3;
	localparam int FIRST_PORT_EN_BIT = 2;
	localparam int TIMER_JOIN_LSB = 0;
	// mode register bit positions
	localparam int KIND_LSB = 6;
	localparam int BYTE_PAIR_BIT = 5;
	localparam int ONE_DEEP_BIT = 4;
	localparam int MATCH_ONLY_BIT = 3;
	localparam int MATCH_MODE_LSB = 1;
	localparam int LATCH_SKEW_BIT = 0;

	typedef enum logic [1:0] {
		PTMC_KIND_BIT = 2'b00,
		PTMC_KIND_IN = 2'b01,
		PTMC_KIND_OUT = 2'b10,
		PTMC_KIND_BIDIR = 2'b11
	} ptmc_kind_type;

	typedef enum logic [1:0] {
		PTMC_MATCH_OFF = 2'b00,
		PTMC_MATCH_AND = 2'b01,
		PTMC_MATCH_OR = 2'b10,
		PTMC_MATCH_VEC = 2'b11
	} ptmc_match_type;

	typedef enum logic [1:0] {
		PTMC_TJ_INDEP = 2'b00,
		PTMC_TJ_GATE = 2'b01,
		PTMC_TJ_TRIG = 2'b10,
		PTMC_TJ_COUNT = 2'b11
	} ptmc_tjoin_type;

	// decoded controls for one handshake port
	typedef struct packed {
		logic enabled;
		logic handshake_idle;
		logic is_bit_port;
		logic is_input;
		logic is_output;
		logic is_bidir;
		logic byte_pair;
		logic one_deep;
		logic match_only;
		ptmc_match_type match_mode;
		logic latch_on_match;
		logic skew_delay_enable;
	} ptmc_port_ctl_type;

	// buffer occupancy and events reported by the port datapath
	typedef struct packed {
		logic data_full;
		logic buffer_full;
		logic byte_moved;
		logic byte_matched;
		logic other_event;
	} ptmc_port_stat_type;
endpackage

/* File: rtl/ptmc_port_gate.sv */
// Purpose: per-port gating of interrupt, request, catchers and drive
// Assumes: occupancy flags come from the port datapath on sys_clk
// Notes: instantiated once per handshake port
`timescale 1ns/1ps
module ptmc_port_gate (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// control and status
	input wire ptmc_pkg::ptmc_port_ctl_type ctl,
	input wire ptmc_pkg::ptmc_port_stat_type stat,
	input wire logic pend_clear,
	input wire logic [7:0] out_drive_req,
	// gated results
	output logic interrupt_pending_flag,
	output logic request_out,
	output logic catchers_transparent,
	output logic [7:0] io_oe_n,
	output logic skew_start
);
	logic pend_r;
	logic pend_nxt;
	logic pair_ready;
	logic one_ready;
	logic ready;
	logic pend_event;

	always_comb begin
		// output ports count empty registers, input ports count full ones
		if (ctl.is_output) begin
			one_ready = !stat.data_full;
			pair_ready = !stat.data_full && !stat.buffer_full;
		end else begin
			one_ready = stat.data_full;
			pair_ready = stat.data_full && stat.buffer_full;
		end
		ready = ctl.byte_pair ? pair_ready : one_ready;
		pend_event = stat.other_event;
		if (!ctl.is_bit_port) begin
			if (ctl.match_only) begin
				pend_event = pend_event || (stat.byte_moved && stat.byte_matched);
			end else if (ctl.byte_pair) begin
				pend_event = pend_event || (stat.byte_moved && pair_ready);
			end else begin
				pend_event = pend_event || (stat.byte_moved && one_ready);
			end
		end
		pend_nxt = pend_r;
		if (pend_clear) begin
			pend_nxt = 1'b0;
		end
		// set beats clear; a disabled port keeps its flag but never sets it
		if (ctl.enabled && pend_event) begin
			pend_nxt = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pend_r <= 1'b0;
		end else begin
			pend_r <= pend_nxt;
		end
	end

	assign interrupt_pending_flag = pend_r;
	// request stays up while any byte is still movable
	assign request_out = ctl.enabled && !ctl.handshake_idle && !ctl.is_bit_port
		&& (ready || (stat.byte_moved && one_ready));
	assign catchers_transparent = !ctl.enabled;
	assign io_oe_n = ctl.enabled ? ~out_drive_req : 8'hFF;
	assign skew_start = ctl.skew_delay_enable && stat.byte_moved;
endmodule
